// file: core/cmz_counter_core.sv
`default_nettype none
module cmz_counter_core #(
	parameter int NUM_COUNTERS = 3,
	parameter int ADDR_W = 8
) (
	// Clock, reset, enable
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pen,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Counter pins
	input wire logic [NUM_COUNTERS-1:0] counter_clock_inputs,
	input wire logic [NUM_COUNTERS-1:0] count_gate_inputs,
	output logic [NUM_COUNTERS-1:0] counter_wave_outputs
);
	logic [5:0] reg_idx;
	logic addr_ok;
	logic wr_en;
	logic rd_setup;
	logic [31:0] prdata_q;
	logic [31:0] next_prdata;
	logic [16:0] cnt_bus [NUM_COUNTERS];
	logic [NUM_COUNTERS-1:0] out_bus;
	logic [NUM_COUNTERS-1:0] run_bus;

	// Decimal count to binary length
	function automatic logic [16:0] bcd_to_bin(input logic [15:0] v);
		logic [16:0] r;
		r = {13'h0000, v[15:12]} * 17'h003E8;
		r = r + {13'h0000, v[11:8]} * 17'h00064;
		r = r + {13'h0000, v[7:4]} * 17'h0000A;
		r = r + {13'h0000, v[3:0]};
		return r;
	endfunction : bcd_to_bin

	// Programmed value to number of clocks
	function automatic logic [16:0] load_len(input logic [15:0] v, input logic bcd,
		input logic [2:0] mode);
		logic [16:0] r;
		if (v == 16'h0000) begin
			r = bcd ? cmz_pkg::CNT_MAX_BCD : cmz_pkg::CNT_MAX_BIN;
		end else if (mode == cmz_pkg::MODE_SQUARE && v == 16'h0001) begin
			r = cmz_pkg::CNT_SQ_ONE;
		end else if (bcd) begin
			r = bcd_to_bin(v);
		end else begin
			r = {1'b0, v};
		end
		return r;
	endfunction : load_len

	// Zero-wait slave; freezing with pen also holds off the bus
	assign reg_idx = paddr[7:2];
	assign addr_ok = (paddr[1:0] == 2'h0) && (reg_idx <= cmz_pkg::STAT_IDX)
		&& ((paddr >> 8) == '0);
	assign wr_en = pen && psel && penable && pwrite && addr_ok && pstrb[0];
	assign rd_setup = psel && !penable && !pwrite;
	assign pready = pen;
	assign pslverr = psel && penable && !addr_ok;
	assign prdata = prdata_q;

	always_comb begin
		next_prdata = prdata_q;
		if (rd_setup) begin
			next_prdata = 32'h00000000;
			if (reg_idx < 6'(NUM_COUNTERS)) begin
				next_prdata = {15'h0000, cnt_bus[reg_idx[1:0]]};
			end else if (reg_idx == cmz_pkg::STAT_IDX) begin
				next_prdata[cmz_pkg::STAT_OUT_POS +: NUM_COUNTERS] = out_bus;
				next_prdata[cmz_pkg::STAT_RUN_POS +: NUM_COUNTERS] = run_bus;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q <= 32'h00000000;
		end else if (pen) begin
			prdata_q <= next_prdata;
		end
	end

	for (genvar i = 0; i < NUM_COUNTERS; i++) begin : g_cnt
		logic [2:0] mode, next_mode;
		logic [1:0] fmt, next_fmt;
		logic bcd, next_bcd;
		logic [16:0] cnt, next_cnt;
		logic [15:0] reload, next_reload;
		logic [7:0] lo, next_lo;
		logic lo_pend, next_lo_pend;
		logic armed, next_armed;
		logic out, next_out;
		logic clk_prev, gate_prev;
		cmz_pkg::cmz_state_type st, next_st;
		logic cw_hit, cnt_hit, clk_edge, gate_rise, gate_ok;
		logic [16:0] len, dec;
		logic [7:0] wbyte;

		// Pins are synchronous to pclk, so one stage gives the edge
		assign clk_edge = counter_clock_inputs[i] && !clk_prev;
		assign gate_rise = count_gate_inputs[i] && !gate_prev;
		assign wbyte = pwdata[7:0];
		assign cw_hit = wr_en && reg_idx == cmz_pkg::CTRL_IDX
			&& wbyte[cmz_pkg::CW_SEL_POS +: 2] == 2'(i)
			&& wbyte[cmz_pkg::CW_SEL_POS +: 2] != cmz_pkg::SEL_ILLEGAL;
		assign cnt_hit = wr_en && reg_idx == 6'(i);
		assign len = load_len(reload, bcd, mode);
		assign dec = cnt - 17'h00001;
		// One-shot and hardware-strobe modes ignore the gate level once running
		assign gate_ok = count_gate_inputs[i] || mode == cmz_pkg::MODE_ONESHOT
			|| mode == cmz_pkg::MODE_HWSTROBE;

		always_comb begin
			next_mode = mode;
			next_fmt = fmt;
			next_bcd = bcd;
			next_cnt = cnt;
			next_reload = reload;
			next_lo = lo;
			next_lo_pend = lo_pend;
			next_armed = armed;
			next_out = out;
			next_st = st;
			// Counter clock activity
			if (clk_edge) begin
				case (st)
					cmz_pkg::CMZ_IDLE: begin
						if (mode[2]) begin
							next_out = 1'b1;
						end
					end
					cmz_pkg::CMZ_LOAD: begin
						next_cnt = len;
						next_st = cmz_pkg::CMZ_RUN;
						if (mode == cmz_pkg::MODE_ONESHOT) begin
							next_out = 1'b0;
						end else if (mode != cmz_pkg::MODE_TC) begin
							next_out = 1'b1;
						end
					end
					cmz_pkg::CMZ_RUN: begin
						if (gate_ok) begin
							next_cnt = dec;
							case (mode)
								cmz_pkg::MODE_TC, cmz_pkg::MODE_ONESHOT: begin
									if (dec == 17'h00000) begin
										next_out = 1'b1;
										next_st = cmz_pkg::CMZ_IDLE;
									end
								end
								cmz_pkg::MODE_RATE: begin
									next_out = dec != 17'h00001;
									if (dec == 17'h00000) begin
										next_cnt = len;
										next_out = 1'b1;
									end
								end
								cmz_pkg::MODE_SQUARE: begin
									next_out = dec > (len >> 1);
									if (dec == 17'h00000) begin
										next_cnt = len;
										next_out = 1'b1;
									end
								end
								default: begin
									if (dec == 17'h00000) begin
										next_out = 1'b0;
										next_st = cmz_pkg::CMZ_IDLE;
									end
								end
							endcase
						end
					end
					default: begin
						next_st = cmz_pkg::CMZ_IDLE;
					end
				endcase
			end
			// Rate modes hold high while gated off
			if (mode[1] && !count_gate_inputs[i]) begin
				next_out = 1'b1;
			end
			// Gate trigger; retrigger restarts with the latest count
			if (gate_rise && armed && (mode[1] || mode[0])) begin
				next_st = cmz_pkg::CMZ_LOAD;
			end
			// Control word write wins over counting
			if (cw_hit && wbyte[cmz_pkg::CW_FMT_POS +: 2] != cmz_pkg::FMT_LATCH) begin
				next_fmt = wbyte[cmz_pkg::CW_FMT_POS +: 2];
				next_bcd = wbyte[cmz_pkg::CW_BCD_POS];
				next_mode = wbyte[cmz_pkg::CW_MODE_POS + 1] ?
					{1'b0, wbyte[cmz_pkg::CW_MODE_POS +: 2]} :
					wbyte[cmz_pkg::CW_MODE_POS +: 3];
				next_out = next_mode != cmz_pkg::MODE_TC;
				next_st = cmz_pkg::CMZ_IDLE;
				next_cnt = cmz_pkg::RST_CNT;
				next_lo_pend = 1'b0;
				next_armed = 1'b0;
			end else if (cnt_hit) begin
				case (fmt)
					cmz_pkg::FMT_LOW: begin
						next_reload = {8'h00, wbyte};
						next_armed = 1'b1;
					end
					cmz_pkg::FMT_HIGH: begin
						next_reload = {wbyte, 8'h00};
						next_armed = 1'b1;
					end
					default: begin
						if (!lo_pend) begin
							next_lo = wbyte;
							next_lo_pend = 1'b1;
							if (mode == cmz_pkg::MODE_TC) begin
								next_st = cmz_pkg::CMZ_IDLE;
							end
						end else begin
							next_reload = {wbyte, lo};
							next_lo_pend = 1'b0;
							next_armed = 1'b1;
						end
					end
				endcase
				// Software-started modes begin on the completed count
				if (next_armed && !next_lo_pend && !mode[0]) begin
					if (!mode[1] || st == cmz_pkg::CMZ_IDLE) begin
						next_st = cmz_pkg::CMZ_LOAD;
					end
				end
			end
		end

		always_ff @(posedge pclk or negedge presetn) begin
			if (!presetn) begin
				mode <= cmz_pkg::RST_MODE;
				fmt <= cmz_pkg::RST_FMT;
				bcd <= 1'b0;
				cnt <= cmz_pkg::RST_CNT;
				reload <= cmz_pkg::RST_RELOAD;
				lo <= 8'h00;
				lo_pend <= 1'b0;
				armed <= 1'b0;
				out <= cmz_pkg::RST_OUT;
				st <= cmz_pkg::CMZ_IDLE;
				clk_prev <= 1'b0;
				gate_prev <= 1'b0;
			end else if (pen) begin
				mode <= next_mode;
				fmt <= next_fmt;
				bcd <= next_bcd;
				cnt <= next_cnt;
				reload <= next_reload;
				lo <= next_lo;
				lo_pend <= next_lo_pend;
				armed <= next_armed;
				out <= next_out;
				st <= next_st;
				clk_prev <= counter_clock_inputs[i];
				gate_prev <= count_gate_inputs[i];
			end
		end

		assign cnt_bus[i] = cnt;
		assign out_bus[i] = out;
		assign run_bus[i] = st != cmz_pkg::CMZ_IDLE;
		assign counter_wave_outputs[i] = out;
	end
endmodule : cmz_counter_core
`default_nettype wire

// file: common/cmz_pkg.sv
// Function
// - A written count of zero counts as the largest count, 65536 in binary.
// - In square-wave mode a count of 1 gives a period of 65537 clocks.
// - A control word selecting terminal-count mode drives the output low at once.
// - Terminal-count mode with gate high starts counting once the count is complete.
// - Terminal-count output goes high at terminal count and holds until reprogrammed.
// - Terminal-count mode: low gate suspends decrementing; high gate resumes it.
// - Single-byte count write in terminal-count mode halts, then reloads next clock.
// - Two-byte format in terminal-count mode: low byte halts counting, high byte restarts from new value.
// - One-shot: output high at mode set; count write alone does not start.
// - One-shot: output goes low on the first clock after a gate rising edge.
// - One-shot: output low for the programmed clocks, high again at terminal count.
// - One-shot: once triggered, counting runs to terminal count despite a low gate.
// - One-shot: new count leaves the pulse alone; next trigger uses the new value.
// - Low-byte-only format: one written byte forms the whole count.
// - High-byte-only format: written byte is the high byte, low byte zero.
// - Two-byte format: host writes the low byte first, then the high byte.
// - Control word: bits 7-6 counter, 5-4 byte format, 3-1 mode, 0 decimal.
// - Address code 3 is the control word; codes 0 to 2 are the count ports.
// - Decimal bit clear counts 16-bit binary; set counts four decimal digits.
`default_nettype none
package cmz_pkg;
	// Register indexes, byte address is four times the index
	localparam logic [5:0] CNT0_IDX = 6'h00;
	localparam logic [5:0] CNT1_IDX = 6'h01;
	localparam logic [5:0] CNT2_IDX = 6'h02;
	localparam logic [5:0] CTRL_IDX = 6'h03;
	localparam logic [5:0] STAT_IDX = 6'h04;
	// Control word fields
	localparam int CW_SEL_POS = 6;
	localparam int CW_FMT_POS = 4;
	localparam int CW_MODE_POS = 1;
	localparam int CW_BCD_POS = 0;
	localparam logic [1:0] SEL_ILLEGAL = 2'h3;
	localparam logic [1:0] FMT_LATCH = 2'h0;
	localparam logic [1:0] FMT_LOW = 2'h1;
	localparam logic [1:0] FMT_HIGH = 2'h2;
	localparam logic [1:0] FMT_BOTH = 2'h3;
	localparam logic [2:0] MODE_TC = 3'h0;
	localparam logic [2:0] MODE_ONESHOT = 3'h1;
	localparam logic [2:0] MODE_RATE = 3'h2;
	localparam logic [2:0] MODE_SQUARE = 3'h3;
	localparam logic [2:0] MODE_SWSTROBE = 3'h4;
	localparam logic [2:0] MODE_HWSTROBE = 3'h5;
	// Status register fields
	localparam int STAT_OUT_POS = 0;
	localparam int STAT_RUN_POS = 4;
	// Count limits
	localparam logic [16:0] CNT_MAX_BIN = 17'h10000;
	localparam logic [16:0] CNT_MAX_BCD = 17'h02710;
	localparam logic [16:0] CNT_SQ_ONE = 17'h10001;
	// Reset values
	localparam logic [2:0] RST_MODE = 3'h0;
	localparam logic [1:0] RST_FMT = 2'h1;
	localparam logic RST_OUT = 1'b0;
	localparam logic [16:0] RST_CNT = 17'h00000;
	localparam logic [15:0] RST_RELOAD = 16'h0000;
	typedef enum logic [1:0] {
		CMZ_IDLE,
		CMZ_LOAD,
		CMZ_RUN
	} cmz_state_type;
endpackage : cmz_pkg
`default_nettype wire

// file: tb/cmz_core_props.sv
`default_nettype none
module cmz_core_props #(
	parameter int NUM_COUNTERS = 3,
	parameter int ADDR_W = 8
) (
	// Clock and bus
	input wire logic pclk,
	input wire logic presetn,
	input wire logic pen,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	// Pins
	input wire logic [NUM_COUNTERS-1:0] count_gate_inputs,
	input wire logic [NUM_COUNTERS-1:0] counter_wave_outputs
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = psel && penable && pen;
	wire o0 = counter_wave_outputs[0];
	wire cw0 = acc && pwrite && pstrb[0] && paddr == 8'h0C && pwdata[7:6] == 2'h0
		&& pwdata[5:4] != 2'h0;
	logic [2:0] mode0;
	logic [2:0] next_mode0;
	assign next_mode0 = cw0 ? pwdata[3:1] : mode0;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) mode0 <= cmz_pkg::RST_MODE;
		else mode0 <= next_mode0;
	end
	// Three quiet samples, so no gate edge is still in flight
	sequence gate_low(m);
		(mode0 == m && !count_gate_inputs[0] && !cw0)[*3];
	endsequence
	tc_low_a: assert property (cw0 && pwdata[3:1] == 3'h0 |=> !o0)
		else $error("output not low after mode set");
	os_high_a: assert property (cw0 && pwdata[3:1] == 3'h1 |=> o0)
		else $error("output not high after mode set");
	tc_hold_a: assert property (mode0 == 3'h0 && o0 && !cw0 |=> o0)
		else $error("output dropped after terminal count");
	gate_stop_a: assert property (gate_low(3'h0) ##0 !o0 |=> !o0)
		else $error("counted with gate low");
	no_trig_a: assert property (gate_low(3'h1) ##0 o0 |=> o0)
		else $error("pulse without trigger");
	bad_addr_a: assert property (acc && (paddr[1:0] != 2'h0 || paddr > 8'h10)
		|-> pslverr && (pwrite || prdata == 32'h0)) else $error("unmapped access accepted");
	good_addr_a: assert property (acc && paddr[1:0] == 2'h0 && paddr <= 8'h10
		|-> !pslverr) else $error("mapped access refused");
	ctrl_read_a: assert property (acc && !pwrite && paddr == 8'h0C
		|-> prdata == 32'h0) else $error("control word readable");
endmodule : cmz_core_props
bind cmz_counter_core cmz_core_props #(.NUM_COUNTERS(NUM_COUNTERS), .ADDR_W(ADDR_W))
	u_props (.*);
`default_nettype wire

// file: tb/cmz_pin_model.sv
`default_nettype none
module cmz_pin_model #(
	parameter int HALF = 4
) (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// Wish of the bench
	input wire logic [2:0] gate_cmd,
	// Counter pins
	output logic [2:0] counter_clock_inputs,
	output logic [2:0] count_gate_inputs
);
	int ticks;
	// Oscillators run free; gates follow one clock later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ticks <= 0;
			counter_clock_inputs <= 3'h0;
			count_gate_inputs <= 3'h0;
		end else begin
			ticks <= (ticks == HALF - 1) ? 0 : ticks + 1;
			if (ticks == HALF - 1) counter_clock_inputs <= ~counter_clock_inputs;
			count_gate_inputs <= gate_cmd;
		end
	end
endmodule : cmz_pin_model
`default_nettype wire

// file: tb/cmz_counter_core_bench.sv
`default_nettype none
module cmz_counter_core_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [2:0] gate, cc, ccp, outs, gin;
	logic [15:0] lfsr;
	logic [31:0] exp_q[$];
	int err_total, checks;
	cmz_counter_core DUT (.pclk(pclk), .presetn(presetn), .pen(1'b1), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .counter_clock_inputs(cc),
		.count_gate_inputs(gin), .counter_wave_outputs(outs));
	cmz_pin_model PINS (.pclk(pclk), .presetn(presetn), .gate_cmd(gate),
		.counter_clock_inputs(cc), .count_gate_inputs(gin));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	always @(posedge pclk) ccp <= cc;
	function automatic logic [15:0] step(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction : step
	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		checks++;
		if (seen !== want) begin
			err_total++;
			$display("wrong value at %0t: saw %h, want %h", $time, seen, want);
		end
	endtask : check
	task automatic give_verdict;
		$display("checks %0d, errors %0d", checks, err_total);
		if (err_total == 0 && checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	// Read data judged at the edge where the master takes it
	always @(posedge pclk) if (psel && penable && pready && !pwrite) check(prdata, exp_q.pop_front());
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			check(n, 0);
			give_verdict;
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		exp_q.push_back(want);
		apb(1'b0, a, 32'h0);
	endtask : rd
	// Counts counter clock edges until the output reaches a level
	task automatic meas(input int i, input logic lv, input int want);
		int e, n;
		e = 0;
		n = 0;
		while (outs[i] !== lv && n < 3000) begin
			@(posedge pclk);
			n++;
			if (cc[i] && !ccp[i]) e++;
		end
		if (n >= 3000) begin
			check(n, 0);
			give_verdict;
		end
		check(e, want);
	endtask : meas
	task automatic ce(input int i);
		int n;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (!(cc[i] && !ccp[i]) && n < 20);
		if (n >= 20) check(n, 0);
	endtask : ce
	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
		paddr = 8'h0; pwdata = 32'h0; gate = 3'h0;
		err_total = 0; checks = 0; lfsr = 16'h0028;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h10, 32'h0);
		rd(8'h0C, 32'h0);
		rd(8'h14, 32'h0);
		apb(1'b1, 8'h0C, 32'hB1);
		apb(1'b1, 8'h08, 32'h34);
		apb(1'b1, 8'h08, 32'h12);
		ce(2);
		rd(8'h08, 32'd1234);
		gate <= 3'h4;
		apb(1'b1, 8'h08, 32'h05);
		apb(1'b1, 8'h08, 32'h00);
		meas(2, 1'b1, 6);
		rd(8'h10, 32'h4);
		gate <= 3'h0;
		apb(1'b1, 8'h0C, 32'hB1);
		apb(1'b1, 8'h08, 32'h00);
		apb(1'b1, 8'h08, 32'h00);
		ce(2);
		rd(8'h08, 32'd10000);
		apb(1'b1, 8'h0C, 32'h60);
		apb(1'b1, 8'h04, 32'hAA);
		ce(1);
		rd(8'h04, 32'hAA00);
		apb(1'b1, 8'h04, 32'h00);
		ce(1);
		rd(8'h04, 32'h10000);
		gate <= 3'h1;
		apb(1'b1, 8'h0C, 32'h10);
		lfsr = step(lfsr);
		apb(1'b1, 8'h00, {30'h0, lfsr[1:0]} + 32'h1);
		meas(0, 1'b1, lfsr[1:0] + 2);
		apb(1'b1, 8'h0C, 32'h10);
		apb(1'b1, 8'h00, 32'hC8);
		ce(0);
		apb(1'b1, 8'h00, 32'h03);
		meas(0, 1'b1, 4);
		gate <= 3'h0;
		apb(1'b1, 8'h0C, 32'h12);
		apb(1'b1, 8'h00, 32'h04);
		ce(0);
		ce(0);
		check({31'h0, outs[0]}, 32'h1);
		gate <= 3'h1;
		meas(0, 1'b0, 1);
		fork
			meas(0, 1'b1, 4);
			begin
				gate <= 3'h0;
				apb(1'b1, 8'h00, 32'h02);
			end
		join
		ce(0);
		gate <= 3'h1;
		meas(0, 1'b0, 1);
		meas(0, 1'b1, 2);
		give_verdict;
	end
endmodule : cmz_counter_core_bench
`default_nettype wire
